// ### verilog/fsr_pkg.sv
// Package for the flash status poller: verdict and state encodings, bit positions, reset command, timing.
// Assumes a byte-wide asynchronous flash whose strobes this controller drives.
package fsr_pkg;
  localparam int ADDR_W = 17;
  // Status bit positions on the data bus.
  localparam int POLL_BIT_POS       = 7;
  localparam int TOGGLE_ONE_BIT_POS = 6;
  localparam int LIMIT_FAIL_BIT_POS = 5;
  localparam int ERASE_WINDOW_POS   = 3;
  localparam int TOGGLE_TWO_BIT_POS = 2;
  // Reset command data byte.
  localparam logic [7:0] CMD_RESET = 8'hf0;
  // Strobe timing: read and write phases in clock cycles at 40 MHz.
  localparam int CLK_NS        = 25;
  localparam int ACCESS_NS     = 70;
  localparam int ACCESS_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_PULSE_NS   = 50;
  localparam int WR_PULSE_CYC  = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  // Host verdicts.
  typedef enum logic [1:0] {
    FSR_RES_NONE = 2'h0,
    FSR_RES_DONE = 2'h1,
    FSR_RES_FAIL = 2'h2,
    FSR_RES_BUSY = 2'h3
  } fsr_res_t;
  // Poller states, one-hot.
  typedef enum logic [6:0] {
    FSR_IDLE  = 7'h01,
    FSR_RD    = 7'h02,
    FSR_GAP   = 7'h04,
    FSR_EVAL  = 7'h08,
    FSR_WR    = 7'h10,
    FSR_WGAP  = 7'h20,
    FSR_FIN   = 7'h40
  } fsr_state_t;
endpackage

// ### verilog/fsr_poller.sv
// Host-side status poller for a byte-wide flash after a program or erase.
// Assumes the flash pins are synchronous to clk and the command was already issued.
`timescale 1ns/1ps
module fsr_poller
  import fsr_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W
)(
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  start,
  input  wire logic [ADDR_WIDTH-1:0] poll_addr,
  output logic                       busy,
  output logic                       done,
  output fsr_res_t                   result,
  output logic [7:0]                 final_data,
  output logic                       erase_window,
  output logic [ADDR_WIDTH-1:0]      flash_addr,
  output logic                       flash_ce_n,
  output logic                       flash_oe_n,
  output logic                       flash_we_n,
  input  wire logic [7:0]            flash_dq_in,
  output logic [7:0]                 flash_dq_out,
  output logic                       flash_dq_oe
);
  fsr_state_t state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [1:0] nreads, next_nreads;
  logic [7:0] prev, next_prev;
  logic       rechk, next_rechk;
  logic       next_busy, next_done, next_ce_n, next_oe_n, next_we_n, next_dq_oe;
  logic       next_ewin;
  fsr_res_t   next_result;
  logic [7:0] next_final, next_dq_out;
  logic [ADDR_WIDTH-1:0] next_addr;
  logic [7:0] older, next_older;
  logic       tog_q;

  // The toggle comparison needs the previous byte, held one read back.
  assign next_older = (state == FSR_RD && cnt == 3'h0) ? prev : older;
  // Only toggle bit one is judged, since it changes at any address while busy.
  assign tog_q = (older[TOGGLE_ONE_BIT_POS] ^ prev[TOGGLE_ONE_BIT_POS]);

  // Next-state logic of the poller; reads are paced by select and output-enable together, both released between reads.
  always_comb
  begin
    next_state  = state;
    next_cnt    = cnt;
    next_nreads = nreads;
    next_prev   = prev;
    next_rechk  = rechk;
    next_busy   = busy;
    next_done   = 1'b0;
    next_result = result;
    next_final  = final_data;
    next_ewin   = erase_window;
    next_addr   = flash_addr;
    next_ce_n   = 1'b1;
    next_oe_n   = 1'b1;
    next_we_n   = 1'b1;
    next_dq_oe  = 1'b1;
    next_dq_out = flash_dq_out;
    case (state)
      FSR_IDLE:
      begin
        if (start)
        begin
          next_addr   = poll_addr;
          next_busy   = 1'b1;
          next_nreads = 2'h0;
          next_rechk  = 1'b0;
          next_result = FSR_RES_BUSY;
          next_cnt    = 3'(ACCESS_CYC);
          next_ce_n   = 1'b0;
          next_oe_n   = 1'b0;
          next_state  = FSR_RD;
        end
      end
      FSR_RD:
      begin
        next_ce_n = 1'b0;
        next_oe_n = 1'b0;
        if (cnt != 3'h0)
          next_cnt = cnt - 3'h1;
        else
        begin
          // The byte is sampled at the end of the access; strobes are released before the gap or the evaluation.
          next_prev   = flash_dq_in;
          next_ewin   = flash_dq_in[ERASE_WINDOW_POS];
          next_nreads = (nreads == 2'h3) ? nreads : nreads + 2'h1;
          next_ce_n   = 1'b1;
          next_oe_n   = 1'b1;
          next_state  = (nreads == 2'h0) ? FSR_GAP : FSR_EVAL;
        end
      end
      FSR_GAP:
      begin
        // One idle cycle so each read is a distinct output-enable cycle.
        next_cnt   = 3'(ACCESS_CYC);
        next_ce_n  = 1'b0;
        next_oe_n  = 1'b0;
        next_state = FSR_RD;
      end
      FSR_EVAL:
      begin
        if (!(tog_q))
        begin
          // Toggle stopped: take full data on a later read.
          if (nreads == 2'h3)
          begin
            // A toggle that stopped as the limit flag rose still counts as success.
            next_final  = prev;
            next_result = FSR_RES_DONE;
            next_state  = FSR_FIN;
          end
          else
          begin
            next_nreads = 2'h3;
            next_cnt    = 3'(ACCESS_CYC);
            next_ce_n   = 1'b0;
            next_oe_n   = 1'b0;
            next_state  = FSR_RD;
          end
        end
        else if (rechk)
        begin
          next_dq_out = CMD_RESET;
          next_dq_oe  = 1'b0;
          next_ce_n   = 1'b0;
          next_we_n   = 1'b0;
          next_cnt    = 3'(WR_PULSE_CYC);
          next_state  = FSR_WR;
        end
        else
        begin
          // Limit flag high forces one recheck; otherwise keep polling.
          next_rechk  = prev[LIMIT_FAIL_BIT_POS];
          next_nreads = 2'h1;
          next_cnt    = 3'(ACCESS_CYC);
          next_ce_n   = 1'b0;
          next_oe_n   = 1'b0;
          next_state  = FSR_RD;
        end
      end
      FSR_WR:
      begin
        next_dq_oe = 1'b0;
        next_ce_n  = 1'b0;
        next_we_n  = 1'b0;
        if (cnt != 3'h0)
          next_cnt = cnt - 3'h1;
        else
        begin
          // Select stays one cycle past the rising write strobe; the data enable stays with it and is released one cycle after the strobe.
          // Raising both strobes together would leave the latch edge ambiguous.
          next_we_n  = 1'b1;
          next_ce_n  = 1'b0;
          next_state = FSR_WGAP;
        end
      end
      FSR_WGAP:
      begin
        next_result = FSR_RES_FAIL;
        next_final  = prev;
        next_state  = FSR_FIN;
      end
      FSR_FIN:
      begin
        next_busy  = 1'b0;
        next_done  = 1'b1;
        next_state = FSR_IDLE;
      end
      default: next_state = FSR_IDLE;
    endcase
  end

  // Registers only; every output comes from here.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state        <= FSR_IDLE;
      cnt          <= 3'h0;
      nreads       <= 2'h0;
      prev         <= 8'h00;
      older        <= 8'h00;
      rechk        <= 1'b0;
      busy         <= 1'b0;
      done         <= 1'b0;
      result       <= FSR_RES_NONE;
      final_data   <= 8'h00;
      erase_window <= 1'b0;
      flash_addr   <= '0;
      flash_ce_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
      flash_we_n   <= 1'b1;
      flash_dq_oe  <= 1'b1;
      flash_dq_out <= 8'h00;
    end
    else
    begin
      state        <= next_state;
      cnt          <= next_cnt;
      nreads       <= next_nreads;
      prev         <= next_prev;
      older        <= next_older;
      rechk        <= next_rechk;
      busy         <= next_busy;
      done         <= next_done;
      result       <= next_result;
      final_data   <= next_final;
      erase_window <= next_ewin;
      flash_addr   <= next_addr;
      flash_ce_n   <= next_ce_n;
      flash_oe_n   <= next_oe_n;
      flash_we_n   <= next_we_n;
      flash_dq_oe  <= next_dq_oe;
      flash_dq_out <= next_dq_out;
    end
  end

  // Never drive data while output-enable is low.
  no_contend_a: assert property (@(posedge clk) disable iff (srst)
    !flash_oe_n |-> flash_dq_oe) else $error("data driven during read");
  reset_cmd_a: assert property (@(posedge clk) disable iff (srst)
    !flash_we_n |-> flash_dq_out == CMD_RESET && !flash_ce_n) else $error("bad reset write");
  fail_reset_a: assert property (@(posedge clk) disable iff (srst)
    done && result == FSR_RES_FAIL |-> $past(flash_we_n, 3) == 1'b0)
    else $error("fail without reset");
  done_pulse_a: assert property (@(posedge clk) disable iff (srst)
    done |=> !done && !busy) else $error("done not a pulse");
  rd_strobe_a: assert property (@(posedge clk) disable iff (srst)
    $fell(flash_oe_n) |-> !flash_ce_n && flash_addr == $past(flash_addr) ||
    $past(state) == FSR_IDLE) else $error("read strobe without select");
  ok_stop_a: assert property (@(posedge clk) disable iff (srst)
    done && result == FSR_RES_DONE |-> $past(flash_we_n, 2) && $past(flash_we_n))
    else $error("done after reset write");
  strobe_ex_a: assert property (@(posedge clk) disable iff (srst)
    !(!flash_oe_n && !flash_we_n)) else $error("read and write together");
  win_a: assert property (@(posedge clk) disable iff (srst)
    $changed(erase_window) |-> $past(state) == FSR_RD) else $error("window changed off read");
  c_done_c: cover property (@(posedge clk) done && result == FSR_RES_DONE);
  c_fail_c: cover property (@(posedge clk) done && result == FSR_RES_FAIL);
  c_win_c:  cover property (@(posedge clk) $rose(erase_window));
endmodule

// ### bench/fsr_flash_model.sv
// Flash model answering status reads after a program or erase command.
// Assumes the bench resolves the data wire and sets the operation fields by hierarchy.
`timescale 1ns/1ps
module fsr_flash_model
  import fsr_pkg::*;
(
  input  wire logic [16:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  bus,
  output logic [7:0]       dq
);
  int          left = 0;
  int          reads = 0;
  int          resets = 0;
  logic        ers = 1'b0;
  logic        fail = 1'b0;
  logic        susp = 1'b0;
  logic        t1 = 1'b0;
  logic        t2 = 1'b0;
  logic [7:0]  pd = 8'h00;
  logic [7:0]  last = 8'h00;
  logic [7:0]  st;
  logic [16:0] rd_addr = '0;
  wire         rd_n = ce_n | oe_n;
  wire         busy = fail || left > 0;
  // Status holds from the first read after the command; array data once finished.
  always_comb
  begin
    st = 8'h00;
    st[POLL_BIT_POS] = susp | (ers ? 1'b0 : ~pd[7]);
    st[TOGGLE_ONE_BIT_POS] = t1;
    st[LIMIT_FAIL_BIT_POS] = fail;
    st[ERASE_WINDOW_POS] = ers & ~susp;
    st[TOGGLE_TWO_BIT_POS] = ers & t2;
    if (!busy)
      st = pd;
  end
  // A read begins on the falling edge of whichever strobe opens it, and is counted there.
  always @(negedge rd_n)
  begin
    reads++;
  end
  // The address is taken at the end of the read, where it has surely settled.
  always @(posedge rd_n)
  begin
    rd_addr = addr;
    last = st;
    if (busy)
    begin
      t1 = t1 ^ ~susp;
      t2 = ~t2;
      left = left > 0 ? left - 1 : 0;
    end
  end
  // The reset command is the only way out of a failed operation.
  always @(posedge we_n)
    if (!ce_n && bus === CMD_RESET)
    begin
      fail = 1'b0;
      left = 0;
      resets++;
    end
  // A released bus shows the inverse of its last value, so stale data cannot pass.
  assign dq = rd_n ? ~last : st;
endmodule

// ### bench/flash_write_status_reporting_tb.sv
// Bench for the flash status poller against a behavioural flash model.
// Assumes one 40 MHz clock and model fields set through hierarchy.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module flash_write_status_reporting_tb;
  import fsr_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        start = 1'b0;
  logic [16:0] poll_addr = '0;
  logic [16:0] addr;
  logic        busy, done, erase_window, ce_n, oe_n, we_n, dq_oe;
  logic [7:0]  final_data, dq_out, dq_in, mdq;
  fsr_res_t    result;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          dones = 0;
  // The wire carries the poller only while its enable is low.
  assign dq_in = dq_oe ? mdq : dq_out;
  fsr_poller dut (.clk(clk), .srst(srst), .start(start), .poll_addr(poll_addr), .busy(busy),
    .done(done), .result(result), .final_data(final_data), .erase_window(erase_window),
    .flash_addr(addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe));
  fsr_flash_model fm (.addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .bus(dq_in),
    .dq(mdq));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (done === 1'b1) dones++;
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One poll; a second start while busy must be ignored.
  task automatic run_poll(input logic [16:0] a, input bit again);
    int n;
    fm.reads = 0;
    fm.resets = 0;
    dones = 0;
    @(posedge clk);
    #2 poll_addr = a;
    start = 1'b1;
    @(posedge clk);
    #2 start = 1'b0;
    `CHK("busy", 1'b1, busy)
    if (again)
    begin
      repeat (4) @(posedge clk);
      #2 start = 1'b1;
      @(posedge clk);
      #2 start = 1'b0;
    end
    for (n = 0; n < 4000 && done !== 1'b1; n++)
      @(posedge clk);
    if (n == 4000)
    begin
      fail_count++;
      $display("mismatch done expected 1 seen 0");
      wrap_up();
    end
    repeat (3) @(posedge clk);
    `CHK("busy", 1'b0, busy)
  endtask
  task automatic s_program();
    fm.pd = 8'h3c;
    fm.left = 4;
    run_poll(17'h00123, 1'b0);
    `CHK("result", FSR_RES_DONE, result)
    `CHK("data", 8'h3c, final_data)
    `CHK("addr", 17'h00123, fm.rd_addr)
    `CHK("writes", 0, fm.resets)
  endtask
  task automatic s_erase();
    fm.ers = 1'b1;
    fm.pd = 8'hff;
    fm.left = 6;
    run_poll(17'h18000, 1'b1);
    `CHK("result", FSR_RES_DONE, result)
    `CHK("data", 8'hff, final_data)
    `CHK("window", 1'b1, erase_window)
    `CHK("addr", 17'h18000, fm.rd_addr)
    `CHK("dones", 1, dones)
    fm.ers = 1'b0;
  endtask
  task automatic s_suspend();
    fm.ers = 1'b1;
    fm.susp = 1'b1;
    fm.left = 1000;
    run_poll(17'h08000, 1'b0);
    `CHK("result", FSR_RES_DONE, result)
    `CHK("status", 8'h80, final_data & 8'hbb)
    fm.ers = 1'b0;
    fm.susp = 1'b0;
    fm.left = 0;
  endtask
  task automatic s_fail();
    fm.fail = 1'b1;
    fm.pd = 8'h11;
    run_poll(17'h00456, 1'b0);
    `CHK("result", FSR_RES_FAIL, result)
    `CHK("writes", 1, fm.resets)
    `CHK("rechecked", 3, fm.reads)
    `CHK("released", 4'hf, {ce_n, oe_n, we_n, dq_oe})
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    #2 srst = 1'b0;
    `CHK("idle", 4'hf, {ce_n, oe_n, we_n, dq_oe})
    `CHK("result", FSR_RES_NONE, result)
    s_program();
    s_erase();
    s_suspend();
    s_fail();
    wrap_up();
  end
endmodule
